// [src/scan_pkg.sv]
package scan_pkg;

  // Register lengths.
  localparam int BSR_LEN = 84;
  localparam int BCR_LEN = 21;
  localparam int IR_LEN  = 8;
  localparam int ID_LEN  = 32;
  localparam int SEG_LEN = 18;

  // Fixed values for capture and reset.
  localparam logic [7:0]  IR_CAPTURE_VAL = 8'h81;
  localparam logic [7:0]  IR_RESET_VAL   = 8'h81;
  localparam logic [83:0] BSR_RESET_VAL  = {4'hF, 80'h0};
  localparam logic [20:0] BCR_RESET_VAL  = 21'h000002;
  localparam logic [2:0]  OP_SIGNATURE   = 3'h2;

  // Boundary cell field positions.
  localparam int BSR_OE_HI   = 83;
  localparam int BSR_OE_LO   = 80;
  localparam int BSR_AIN_HI  = 71;
  localparam int BSR_AIN_LO  = 54;
  localparam int BSR_AOUT_HI = 53;
  localparam int BSR_AOUT_LO = 36;
  localparam int BSR_BIN_HI  = 35;
  localparam int BSR_BIN_LO  = 18;
  localparam int BSR_BOUT_HI = 17;
  localparam int BSR_BOUT_LO = 0;

  // Boundary control field positions.
  localparam int BCR_MASK2_HI = 20;
  localparam int BCR_MASK2_LO = 12;
  localparam int BCR_MASK1_HI = 11;
  localparam int BCR_MASK1_LO = 3;
  localparam int BCR_OP_HI    = 2;
  localparam int BCR_OP_LO    = 0;

  // Instruction opcodes, bit 7 keeping even parity.
  localparam logic [7:0] OPC_EXTEST  = 8'h00;
  localparam logic [7:0] OPC_IDENT   = 8'h81;
  localparam logic [7:0] OPC_SAMPLE  = 8'h82;
  localparam logic [7:0] OPC_INTEST  = 8'h03;
  localparam logic [7:0] OPC_HIGHZ   = 8'h06;
  localparam logic [7:0] OPC_CLAMP   = 8'h87;
  localparam logic [7:0] OPC_RUNTEST = 8'h09;
  localparam logic [7:0] OPC_READBN  = 8'h0A;
  localparam logic [7:0] OPC_READBT  = 8'h8B;
  localparam logic [7:0] OPC_CELLTST = 8'h0C;
  localparam logic [7:0] OPC_TOGGLE  = 8'h8D;
  localparam logic [7:0] OPC_CTRL_N  = 8'h8E;
  localparam logic [7:0] OPC_CTRL_T  = 8'h0F;

  // States of the external test access port controller.
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_e;

  // Data register placed in the scan path.
  typedef enum logic [1:0] {SEL_BOUNDARY, SEL_IDENT, SEL_BYPASS, SEL_CONTROL} dr_sel_e;

  // Decoded instruction.
  typedef struct packed {
    dr_sel_e sel;
    logic    test_mode;
    logic    capture_pins;
    logic    run_test;
    logic    float_outputs;
    logic    clamp;
  } instr_dec_s;

  // Control word handed to the transceiver clock domain.
  typedef struct packed {
    logic        test_mode;
    logic        float_outputs;
    logic        clamp;
    logic        run_active;
    logic [2:0]  test_op;
    logic [8:0]  group2_input_mask;
    logic [8:0]  group1_input_mask;
    logic [83:0] cells;
  } test_ctrl_s;

endpackage

// [src/scan_test_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Eight-bit instruction selects mode, register, capture source.
// - Bit 7 keeps opcode at even parity.
// - Unimplemented family opcodes execute as bypass.
// - Instruction capture loads fixed pattern 10000001.
// - Instruction update copies shift stage into hold.
// - Reset forces instruction hold to identification.
// - Boundary chain has 84 cells.
// - Boundary capture source from instruction; idle ops.
// - Reset sets cells 83 to 80 high.
// - Boundary chain shifts 83 down to 0.
// - Fixed cell map for controls and ports.
// - Control register 21 bits selects run-test ops.
// - Control register keeps contents during capture.
// - Control register resets to signature, no masking.
// - Control register shifts 20 down to 0.
// - Control fields: two masks and operation code.
// - Test operation runs only in run-test/idle.
// - Instruction takes effect on falling edge.
module scan_test_regs #(
  parameter logic [2:0]  OP_PSEUDO_RANDOM_PATTERN_GEN  = 3'h1,
  parameter logic [2:0]  OP_COUNT = 3'h4,
  parameter logic [31:0] ID_CODE  = 32'h0000_0001  // Arbitrary value, LSB held at one.
) (
  input  wire logic                 mclk_in,
  input  wire logic                 srst_in,
  input  wire logic                 tck_in,
  input  wire scan_pkg::tap_state_e tap_state_in,
  input  wire logic                 tdi_in,
  input  wire logic [83:0]          pin_obs_in,
  output var  logic                 tdo_out,
  output var  logic                 tdo_oe_n_out,
  output var  scan_pkg::test_ctrl_s ctrl_out
);
  import scan_pkg::*;

  // Next step of an 18-bit maximal-length shift sequence.
  function automatic logic [17:0] lfsr_step(input logic [17:0] v);
    lfsr_step = {v[16:0], v[17] ^ v[10]};
  endfunction

  // Instruction decode; odd parity and unlisted codes fall to bypass.
  function automatic instr_dec_s decode(input logic [7:0] op);
    instr_dec_s d;
    d = '{sel: SEL_BYPASS, test_mode: 1'b0, capture_pins: 1'b0, run_test: 1'b0,
          float_outputs: 1'b0, clamp: 1'b0};
    case (op)
      OPC_EXTEST, OPC_INTEST: begin
        d.sel = SEL_BOUNDARY;
        d.test_mode = 1'b1;
        d.capture_pins = 1'b1;
      end
      OPC_IDENT: d.sel = SEL_IDENT;
      OPC_SAMPLE: begin
        d.sel = SEL_BOUNDARY;
        d.capture_pins = 1'b1;
      end
      OPC_HIGHZ: begin
        d.test_mode = 1'b1;
        d.float_outputs = 1'b1;
      end
      OPC_CLAMP, OPC_TOGGLE: begin
        d.test_mode = 1'b1;
        d.clamp = 1'b1;
      end
      OPC_RUNTEST: begin
        d.test_mode = 1'b1;
        d.run_test = 1'b1;
      end
      OPC_READBN, OPC_CELLTST: d.sel = SEL_BOUNDARY;
      OPC_READBT: begin
        d.sel = SEL_BOUNDARY;
        d.test_mode = 1'b1;
      end
      OPC_CTRL_N: d.sel = SEL_CONTROL;
      OPC_CTRL_T: begin
        d.sel = SEL_CONTROL;
        d.test_mode = 1'b1;
      end
      default: d.sel = SEL_BYPASS;
    endcase
    return d;
  endfunction

  // Rising-edge state: shift stages and pin synchroniser.
  logic [7:0]  ir_shift_reg,  ir_shift_next;
  logic [83:0] bsr_shift_reg, bsr_shift_next;
  logic [20:0] bcr_shift_reg, bcr_shift_next;
  logic [31:0] id_shift_reg,  id_shift_next;
  logic        byp_reg,       byp_next;
  logic [83:0] pin_s1_reg,    pin_s2_reg;

  // Falling-edge state: hold stages, serial output and request side.
  logic [7:0]  ir_hold_reg,   ir_hold_next;
  logic [83:0] bsr_hold_reg,  bsr_hold_next;
  logic [20:0] bcr_hold_reg,  bcr_hold_next;
  logic        tdo_reg,       tdo_next;
  logic        tdo_oe_n_reg,  tdo_oe_n_next;
  logic        req_reg,       req_next;
  test_ctrl_s  snap_reg,      snap_next;
  logic        ack_s1_reg,    ack_s2_reg;

  // Transceiver clock state: acknowledge side and output word.
  logic        req_s1_reg,    req_s2_reg;
  logic        ack_reg,       ack_next;
  test_ctrl_s  ctrl_reg,      ctrl_next;

  instr_dec_s  cur;
  logic [2:0]  test_op;
  logic [17:0] in_mask;
  logic        run_active;

  // Current instruction and control fields from the hold stages.
  always_comb begin
    cur        = decode(ir_hold_reg);
    test_op    = bcr_hold_reg[BCR_OP_HI:BCR_OP_LO];
    in_mask    = {bcr_hold_reg[BCR_MASK2_HI:BCR_MASK2_LO], bcr_hold_reg[BCR_MASK1_HI:BCR_MASK1_LO]};
    run_active = cur.run_test && (tap_state_in == RTI);
  end

  // Shift stages: capture, shift toward the serial output, or hold.
  always_comb begin
    ir_shift_next  = ir_shift_reg;
    bsr_shift_next = bsr_shift_reg;
    bcr_shift_next = bcr_shift_reg;
    id_shift_next  = id_shift_reg;
    byp_next       = byp_reg;
    case (tap_state_in)
      TLR: begin
        bsr_shift_next = BSR_RESET_VAL;
        bcr_shift_next = BCR_RESET_VAL;
      end
      CAP_IR: ir_shift_next = IR_CAPTURE_VAL;
      SHIFT_IR: ir_shift_next = {tdi_in, ir_shift_reg[7:1]};
      CAP_DR: begin
        case (cur.sel)
          SEL_BOUNDARY: begin
            if (cur.capture_pins) begin
              bsr_shift_next = pin_s2_reg;
            end
          end
          SEL_IDENT: id_shift_next = ID_CODE;
          SEL_BYPASS: byp_next = 1'b0;
          default: bcr_shift_next = bcr_shift_reg;
        endcase
      end
      SHIFT_DR: begin
        case (cur.sel)
          SEL_BOUNDARY: bsr_shift_next = {tdi_in, bsr_shift_reg[83:1]};
          SEL_IDENT: id_shift_next = {tdi_in, id_shift_reg[31:1]};
          SEL_BYPASS: byp_next = tdi_in;
          default: bcr_shift_next = {tdi_in, bcr_shift_reg[20:1]};
        endcase
      end
      default: ir_shift_next = ir_shift_reg;
    endcase
  end

  // Rising TCK edge registers; pins pass two flip-flops first.
  always_ff @(posedge tck_in) begin
    ir_shift_reg  <= ir_shift_next;
    bsr_shift_reg <= bsr_shift_next;
    bcr_shift_reg <= bcr_shift_next;
    id_shift_reg  <= id_shift_next;
    byp_reg       <= byp_next;
    pin_s1_reg    <= pin_obs_in;
    pin_s2_reg    <= pin_s1_reg;
  end

  // Hold stages update, run-test operations, serial output, hand-over request.
  always_comb begin
    ir_hold_next  = ir_hold_reg;
    bsr_hold_next = bsr_hold_reg;
    bcr_hold_next = bcr_hold_reg;
    tdo_next      = tdo_reg;
    tdo_oe_n_next = 1'b1;
    req_next      = req_reg;
    snap_next     = snap_reg;
    case (tap_state_in)
      TLR: begin
        ir_hold_next  = IR_RESET_VAL;
        bsr_hold_next = BSR_RESET_VAL;
        bcr_hold_next = BCR_RESET_VAL;
        tdo_next      = 1'b0;  // Gives the idle output a known level.
        req_next      = ack_s2_reg;  // Starts the toggle handshake from a known, idle point.
      end
      UPD_IR: ir_hold_next = ir_shift_reg;
      UPD_DR: begin
        if (cur.sel == SEL_BOUNDARY) begin
          bsr_hold_next = bsr_shift_reg;
        end else if (cur.sel == SEL_CONTROL) begin
          bcr_hold_next = bcr_shift_reg;
        end
      end
      SHIFT_IR: begin
        tdo_next      = ir_shift_reg[0];
        tdo_oe_n_next = 1'b0;
      end
      SHIFT_DR: begin
        tdo_oe_n_next = 1'b0;
        case (cur.sel)
          SEL_BOUNDARY: tdo_next = bsr_shift_reg[0];
          SEL_IDENT: tdo_next = id_shift_reg[0];
          SEL_BYPASS: tdo_next = byp_reg;
          default: tdo_next = bcr_shift_reg[0];
        endcase
      end
      default: tdo_next = tdo_reg;
    endcase
    // Run-test operations act on the hold cells that face the pins.
    if (run_active) begin
      if (test_op == OP_SIGNATURE) begin
        bsr_hold_next[BSR_AIN_HI:BSR_AIN_LO] = lfsr_step(bsr_hold_reg[BSR_AIN_HI:BSR_AIN_LO])
          ^ (pin_s2_reg[BSR_AIN_HI:BSR_AIN_LO] & ~in_mask);
        bsr_hold_next[BSR_BIN_HI:BSR_BIN_LO] = lfsr_step(bsr_hold_reg[BSR_BIN_HI:BSR_BIN_LO])
          ^ (pin_s2_reg[BSR_BIN_HI:BSR_BIN_LO] & ~in_mask);
      end else if (test_op == OP_PSEUDO_RANDOM_PATTERN_GEN) begin
        bsr_hold_next[BSR_AOUT_HI:BSR_AOUT_LO] = lfsr_step(bsr_hold_reg[BSR_AOUT_HI:BSR_AOUT_LO]);
        bsr_hold_next[BSR_BOUT_HI:BSR_BOUT_LO] = lfsr_step(bsr_hold_reg[BSR_BOUT_HI:BSR_BOUT_LO]);
      end else if (test_op == OP_COUNT) begin
        bsr_hold_next[BSR_AOUT_HI:BSR_AOUT_LO] = bsr_hold_reg[BSR_AOUT_HI:BSR_AOUT_LO] + 18'h00001;
        bsr_hold_next[BSR_BOUT_HI:BSR_BOUT_LO] = bsr_hold_reg[BSR_BOUT_HI:BSR_BOUT_LO] + 18'h00001;
      end
    end
    // A new snapshot is taken only once the previous one is acknowledged.
    if (ack_s2_reg == req_reg) begin
      snap_next.test_mode         = cur.test_mode;
      snap_next.float_outputs     = cur.float_outputs;
      snap_next.clamp             = cur.clamp;
      snap_next.run_active        = run_active;
      snap_next.test_op           = test_op;
      snap_next.group2_input_mask = bcr_hold_reg[BCR_MASK2_HI:BCR_MASK2_LO];
      snap_next.group1_input_mask = bcr_hold_reg[BCR_MASK1_HI:BCR_MASK1_LO];
      snap_next.cells             = bsr_hold_reg;
      req_next                    = ~req_reg;
    end
  end

  // Falling TCK edge registers; the acknowledge toggle is synchronised here.
  always_ff @(negedge tck_in) begin
    ir_hold_reg  <= ir_hold_next;
    bsr_hold_reg <= bsr_hold_next;
    bcr_hold_reg <= bcr_hold_next;
    tdo_reg      <= tdo_next;
    tdo_oe_n_reg <= tdo_oe_n_next;
    req_reg      <= req_next;
    snap_reg     <= snap_next;
    ack_s1_reg   <= ack_reg;
    ack_s2_reg   <= ack_s1_reg;
  end

  // Transceiver side takes the snapshot when the request toggle arrives.
  always_comb begin
    ack_next  = ack_reg;
    ctrl_next = ctrl_reg;
    if (req_s2_reg != ack_reg) begin
      ctrl_next = snap_reg;
      ack_next  = req_s2_reg;
    end
  end

  // Transceiver clock registers with synchronous reset.
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_reg    <= 1'b0;
      ctrl_reg   <= '{test_op: OP_SIGNATURE, cells: BSR_RESET_VAL, default: '0};
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      ack_reg    <= ack_next;
      ctrl_reg   <= ctrl_next;
    end
  end

  // Outputs straight from flip-flops.
  assign tdo_out      = tdo_reg;
  assign tdo_oe_n_out = tdo_oe_n_reg;
  assign ctrl_out     = ctrl_reg;

endmodule
`default_nettype wire

// [sim/scan_test_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_test_regs_props (
  input wire logic                 mclk_in,
  input wire logic                 srst_in,
  input wire logic                 tck_in,
  input wire scan_pkg::tap_state_e tap_state_in,
  input wire logic                 tdo_out,
  input wire logic                 tdo_oe_n_out,
  input wire scan_pkg::test_ctrl_s ctrl_out
);
  import scan_pkg::*;
  // The serial output is driven only after a fall spent in a shift state.
  oe_on_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    tap_state_in inside {SHIFT_IR, SHIFT_DR} |=> !tdo_oe_n_out) else $error("tdo not enabled in shift");
  oe_off_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    !(tap_state_in inside {SHIFT_IR, SHIFT_DR}) |=> tdo_oe_n_out) else $error("tdo enabled outside shift");
  oe_cause_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    !tdo_oe_n_out |-> $past(tap_state_in) inside {SHIFT_IR, SHIFT_DR}) else $error("tdo enabled without cause");
  tdo_hold_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    !(tap_state_in inside {SHIFT_IR, SHIFT_DR}) |=> $stable(tdo_out)) else $error("tdo moved outside shift");
  // The captured instruction pattern leaves low bit first.
  ir_first_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    $past(tap_state_in) == CAP_IR && tap_state_in == SHIFT_IR |=> tdo_out) else $error("ir bit 0 wrong");
  ir_second_a: assert property (@(negedge tck_in) disable iff (tap_state_in == TLR)
    ($past(tap_state_in) == CAP_IR && tap_state_in == SHIFT_IR) ##1 tap_state_in == SHIFT_IR |=> !tdo_out)
    else $error("ir bit 1 wrong");
  // Control word leaves reset with its documented defaults.
  reset_ctrl_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    $fell(srst_in) |-> ctrl_out.test_op == 3'h2 && ctrl_out.cells[83:80] == 4'hF && !ctrl_out.test_mode)
    else $error("control word not at reset value");
  run_mode_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    ctrl_out.run_active |-> ctrl_out.test_mode) else $error("run test outside test mode");
  // Main scenarios reached.
  cov_ir: cover property (@(negedge tck_in) tap_state_in == SHIFT_IR ##1 tap_state_in == EXIT1_IR);
  cov_run: cover property (@(posedge mclk_in) ctrl_out.run_active);
  cov_test: cover property (@(posedge mclk_in) $rose(ctrl_out.test_mode));
endmodule
`default_nettype wire

// [sim/scan_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  output var  logic                 tck_out,
  output var  scan_pkg::tap_state_e state_out,
  output var  logic                 tdi_out,
  input  wire logic                 tdo_in
);
  import scan_pkg::*;
  // The test clock rests low between steps.
  initial begin
    tck_out = 1'b0;
    state_out = TLR;
    tdi_out = 1'b0;
  end
  // One clock period: new state and data just after the rise, serial output taken after the fall.
  task automatic step(input tap_state_e st, input logic d, output logic q);
    tck_out = 1'b1;
    #5;
    state_out = st;
    tdi_out = (st == SHIFT_IR || st == SHIFT_DR) ? d : ~tdi_out;  // Unused data line keeps toggling.
    #57.5;
    tck_out = 1'b0;
    #5;
    q = tdo_in;
    #57.5;
  endtask
  task automatic walk(input tap_state_e st, input int n);
    logic q;
    repeat (n) step(st, 1'b0, q);
  endtask
  // Full scan from idle and back, low bit first.
  task automatic scan(input logic ir, input int n, input logic [83:0] din, output logic [83:0] dout);
    logic q;
    dout = '0;
    step(SEL_DR, 1'b0, q);
    if (ir) step(SEL_IR, 1'b0, q);
    step(ir ? CAP_IR : CAP_DR, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(ir ? SHIFT_IR : SHIFT_DR, din[i], q);
      dout[i] = q;
    end
    step(ir ? EXIT1_IR : EXIT1_DR, 1'b0, q);
    step(ir ? UPD_IR : UPD_DR, 1'b0, q);
    step(RTI, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scan_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_0A5B;  // Arbitrary value, low bit one.
  logic        mclk_in, srst_in, tck, tdi, tdo, oe_n;
  tap_state_e  st;
  test_ctrl_s  ctrl;
  logic [83:0] pins, din, dout, cells;
  logic [20:0] boundary_control_register;
  logic [7:0]  byp [4] = '{8'h02, 8'h84, 8'h05, 8'hFF};
  int          bad_count, n_checks, cycles, seed;
  scan_test_regs #(.ID_CODE(ID_VAL)) i_scan_test_regs (.mclk_in(mclk_in), .srst_in(srst_in), .tck_in(tck),
    .tap_state_in(st), .tdi_in(tdi), .pin_obs_in(pins), .tdo_out(tdo), .tdo_oe_n_out(oe_n), .ctrl_out(ctrl));
  scan_ctrl_model i_scan_ctrl_model (.tck_out(tck), .state_out(st), .tdi_out(tdi), .tdo_in(tdo));
  // Main clock and hang guard.
  always #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input string nm, input logic [83:0] seen, input logic [83:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Let the control word cross into the main clock domain.
  task automatic settle();
    i_scan_ctrl_model.walk(RTI, 4);
    repeat (10) @(posedge mclk_in);
  endtask
  task automatic ir(input logic [7:0] op);
    i_scan_ctrl_model.scan(1'b1, 8, {76'h0, op}, dout);
    check("ir capture", dout[7:0], 8'h81);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    seed = 95296;
    mclk_in = 1'b0;
    srst_in = 1'b1;
    pins = '0;
    repeat (6) @(posedge mclk_in);
    #2 srst_in = 1'b0;
    i_scan_ctrl_model.walk(TLR, 6);
    settle();
    check("reset cells", ctrl.cells[83:80], 4'hF);
    check("reset control", {ctrl.group2_input_mask, ctrl.group1_input_mask, ctrl.test_op}, 21'h2);
    i_scan_ctrl_model.scan(1'b0, 32, '0, dout);
    check("ident", dout[31:0], ID_VAL);
    @(posedge mclk_in) #2 pins = 84'({$random(seed), $random(seed), $random(seed)});
    din = 84'({$random(seed), $random(seed), $random(seed)});
    ir(OPC_SAMPLE);
    i_scan_ctrl_model.scan(1'b0, 84, din, dout);
    check("sample", dout, pins);
    settle();
    check("cells", ctrl.cells, din);
    check("normal mode", ctrl.test_mode, 1'b0);
    foreach (byp[k]) begin
      ir(byp[k]);
      i_scan_ctrl_model.scan(1'b0, 2, 84'h3, dout);
      check("bypass", dout[1:0], 2'b10);
    end
    ir(OPC_CTRL_N);
    boundary_control_register = 21'($random(seed));
    boundary_control_register[2:0] = 3'h4;
    i_scan_ctrl_model.scan(1'b0, 21, {63'h0, boundary_control_register}, dout);
    check("bcr reset", dout[20:0], 21'h2);
    i_scan_ctrl_model.scan(1'b0, 21, {63'h0, boundary_control_register}, dout);
    check("bcr held", dout[20:0], boundary_control_register);
    settle();
    check("masks", {ctrl.group2_input_mask, ctrl.group1_input_mask, ctrl.test_op}, boundary_control_register);
    ir(OPC_EXTEST);
    settle();
    check("test mode", ctrl.test_mode, 1'b1);
    ir(OPC_RUNTEST);
    i_scan_ctrl_model.walk(RTI, 6);
    ir(OPC_SAMPLE);
    settle();
    cells = din;
    cells[53:36] = cells[53:36] + 18'd7;
    cells[17:0] = cells[17:0] + 18'd7;
    check("count", ctrl.cells, cells);
    i_scan_ctrl_model.walk(TLR, 6);
    settle();
    check("reset again", {ctrl.cells[83:80], ctrl.test_op}, 7'h7A);
    @(posedge mclk_in) #2 srst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    check("srst control", {ctrl.test_mode, ctrl.test_op, ctrl.cells[83:80]}, 8'h2F);
    #2 srst_in = 1'b0;
    report_and_stop();
  end
endmodule
bind scan_test_regs scan_test_regs_props i_props (.mclk_in(mclk_in), .srst_in(srst_in), .tck_in(tck_in),
  .tap_state_in(tap_state_in), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out), .ctrl_out(ctrl_out));
`default_nettype wire
